// ---- hw/pwt_map.vh ----
// constants, register map and field layout of the pulse-width trigger and frequency counter
`ifndef PWT_MAP_VH
`define PWT_MAP_VH

// ***************************************************
// register offsets (byte addresses)
// ***************************************************
`define PWT_ADDR_W 8
`define PWT_OFS_CTRL 8'h00
`define PWT_OFS_WIDTH 8'h04
`define PWT_OFS_FREQ 8'h08
`define PWT_OFS_LASTW 8'h0C
`define PWT_OFS_STATUS 8'h10

// ***************************************************
// control fields
// ***************************************************
`define PWT_CTRL_W 8
`define PWT_CTRL_RST 8'h04
`define PWT_F_MODE 1:0
`define PWT_F_POS 2
`define PWT_F_TYPE 4:3
`define PWT_F_SRC 7:5
`define PWT_MODE_LT 2'h0
`define PWT_MODE_GT 2'h1
`define PWT_MODE_EQ 2'h2
`define PWT_MODE_NE 2'h3
`define PWT_TYPE_EDGE 2'h0
`define PWT_TYPE_PULSE 2'h1
`define PWT_TYPE_VIDEO 2'h2
`define PWT_NSRC 5

// ***************************************************
// width setting in 16.5 ns steps; time in 0.5 ns quanta
// ***************************************************
`define PWT_WIDTH_W 30
`define PWT_TIME_W 35
`define PWT_CLK_NS 50
`define PWT_TQ_PER_NS 2
`define PWT_CLK_TQ 35'h0_0000_0064
`define PWT_STEP_TQ 35'h0_0000_0021
`define PWT_MIN_NS 33
`define PWT_MIN_STEPS 30'h0000_0002
`define PWT_MAX_STEPS 30'h241F_C03E
`define PWT_WIDTH_RST 30'h0000_0002
`define PWT_PPT_SHIFT 10
`define PWT_SMALL_LIMIT 35'h0_0000_0294
`define PWT_NE_MID_LIMIT 35'h0_0000_014A
`define PWT_GB_MUL 4'hD
`define PWT_GB_SHIFT 8

// ***************************************************
// frequency counter
// ***************************************************
`define PWT_GATE_MS 250
`define PWT_GATE_CYCLES (`PWT_GATE_MS * 1000000 / `PWT_CLK_NS)
`define PWT_MIN_HZ 10
`define PWT_ACC_W 24
`define PWT_FREQ_W 26
`define PWT_SCALE_SHIFT 2

`endif

// ---- hw/freq_gate_counter.v ----
// gate-window event counter that reports events per second
`timescale 1ns/1ps
`include "pwt_map.vh"

module freq_gate_counter #(
	parameter GATE_CYCLES = `PWT_GATE_CYCLES
) (
	input wire clock, // system clock
	input wire rst_n, // asynchronous reset, active low
	input wire enable, // counting allowed
	input wire countEvent, // one-cycle event to tally
	output reg [`PWT_FREQ_W-1:0] freqHz_r, // events per second of last window
	output reg freqValid_r // a full window has been measured
);
	reg [31:0] gate_r;
	reg [`PWT_ACC_W-1:0] acc_r;
	wire gateEnd = (gate_r == GATE_CYCLES - 1);
	wire [`PWT_ACC_W-1:0] accNxt = acc_r + {{(`PWT_ACC_W-1){1'b0}}, countEvent};

	// window runs free of any acquisition state
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gate_r <= 32'h0000_0000;
			acc_r <= {`PWT_ACC_W{1'b0}};
			freqHz_r <= {`PWT_FREQ_W{1'b0}};
			freqValid_r <= 1'b0;
		end else if (!enable) begin
			// no result while disabled
			gate_r <= 32'h0000_0000;
			acc_r <= {`PWT_ACC_W{1'b0}};
			freqHz_r <= {`PWT_FREQ_W{1'b0}};
			freqValid_r <= 1'b0;
		end else if (gateEnd) begin
			// latch, scale to per second, clear and restart
			gate_r <= 32'h0000_0000;
			acc_r <= {`PWT_ACC_W{1'b0}};
			freqHz_r <= {accNxt, {`PWT_SCALE_SHIFT{1'b0}}};
			freqValid_r <= 1'b1;
		end else begin
			gate_r <= gate_r + 32'h0000_0001;
			acc_r <= accNxt;
		end
	end
endmodule // freq_gate_counter

// ---- hw/pulse_width_trigger_counter.v ----
// pulse-width trigger qualifier with trigger frequency counter and APB registers
`timescale 1ns/1ps
`include "pwt_map.vh"

module pulse_width_trigger_counter #(
	parameter GATE_CYCLES = `PWT_GATE_CYCLES
) (
	input wire clock, // 20 MHz system clock
	input wire rst_n, // asynchronous reset, active low
	input wire psel, // APB select
	input wire penable, // APB access phase
	input wire pwrite, // APB write
	input wire [`PWT_ADDR_W-1:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output wire pready, // APB ready
	output reg pslverr, // APB error on unmapped address
	input wire [`PWT_NSRC-1:0] trigIn, // digitized comparator outputs per source
	output reg trigOut, // one-cycle trigger pulse
	output wire freqValid // frequency result is valid
);
	// ***************************************************
	// register bus
	// ***************************************************
	reg [`PWT_CTRL_W-1:0] ctrl_r;
	reg [`PWT_WIDTH_W-1:0] width_r;
	reg [`PWT_TIME_W-1:0] lastW_r;
	wire [`PWT_FREQ_W-1:0] freqHz;
	reg timing_r;
	reg fired_r;
	reg [31:0] rdNxt;
	reg errNxt;
	reg [`PWT_WIDTH_W-1:0] wrWidth;

	wire setup = psel & ~penable;
	wire wrStb = psel & penable & pwrite;
	wire wrCtrl = wrStb & (paddr == `PWT_OFS_CTRL);
	wire wrWidthStb = wrStb & (paddr == `PWT_OFS_WIDTH);
	assign pready = 1'b1;

	always @* begin
		errNxt = 1'b0;
		case (paddr)
			`PWT_OFS_CTRL: rdNxt = {{(32-`PWT_CTRL_W){1'b0}}, ctrl_r};
			`PWT_OFS_WIDTH: rdNxt = {{(32-`PWT_WIDTH_W){1'b0}}, width_r};
			`PWT_OFS_FREQ: rdNxt = {{(32-`PWT_FREQ_W){1'b0}}, freqHz};
			`PWT_OFS_LASTW: rdNxt = lastW_r[`PWT_TIME_W-1:`PWT_TIME_W-32];
			`PWT_OFS_STATUS: rdNxt = {29'h000_0000, fired_r, freqValid, timing_r};
			default: begin
				rdNxt = 32'h0000_0000;
				errNxt = 1'b1;
			end
		endcase
	end

	// read data and error are prepared in the setup cycle
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0000_0000 : rdNxt;
			pslverr <= errNxt;
		end
	end

	// width is clamped to its settable range
	always @* begin
		wrWidth = pwdata[`PWT_WIDTH_W-1:0];
		if (pwdata[31:`PWT_WIDTH_W] != 2'b00 || wrWidth > `PWT_MAX_STEPS)
			wrWidth = `PWT_MAX_STEPS;
		else if (wrWidth < `PWT_MIN_STEPS)
			wrWidth = `PWT_MIN_STEPS;
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= `PWT_CTRL_RST;
			width_r <= `PWT_WIDTH_RST;
		end else begin
			if (wrCtrl)
				ctrl_r <= pwdata[`PWT_CTRL_W-1:0];
			if (wrWidthStb)
				width_r <= wrWidth;
		end
	end

	wire [1:0] mode = ctrl_r[`PWT_F_MODE];
	wire [1:0] trigType = ctrl_r[`PWT_F_TYPE];
	wire [2:0] src = ctrl_r[`PWT_F_SRC];

	// ***************************************************
	// width quantization and guardbands
	// ***************************************************
	wire [`PWT_WIDTH_W-1:0] stepMask;
	// upper[g] is set when any width bit at or above g is set
	wire [`PWT_WIDTH_W:0] upper;
	assign upper[`PWT_WIDTH_W] = 1'b0;
	genvar g;
	// coarsen steps to about one part per thousand of the width
	generate
		for (g = 0; g < `PWT_WIDTH_W; g = g + 1) begin : gStep
			assign upper[g] = upper[g+1] | width_r[g];
			// drop bit g once the top set bit lies more than the shift above it
			if (g + `PWT_PPT_SHIFT < `PWT_WIDTH_W) begin : gCut
				assign stepMask[g] = ~upper[g+`PWT_PPT_SHIFT+1];
			end else begin : gKeep
				assign stepMask[g] = 1'b1;
			end
		end
	endgenerate
	wire [`PWT_WIDTH_W-1:0] widthQ = width_r & stepMask;
	// steps of 16.5 ns are 33 time quanta
	wire [`PWT_TIME_W-1:0] tgt = ({5'h00, widthQ} << 5) + {5'h00, widthQ};
	wire [`PWT_TIME_W+3:0] tgtMul = tgt * `PWT_GB_MUL;
	wire [`PWT_TIME_W-1:0] gbPct = {4'h0, tgtMul[`PWT_TIME_W+3:`PWT_GB_SHIFT]};
	reg [`PWT_TIME_W-1:0] gbLo;
	reg [`PWT_TIME_W-1:0] gbHi;

	always @* begin
		if (tgt <= `PWT_SMALL_LIMIT) begin
			gbLo = `PWT_STEP_TQ;
			if (mode == `PWT_MODE_NE && tgt > `PWT_NE_MID_LIMIT)
				gbHi = `PWT_STEP_TQ << 1;
			else
				gbHi = `PWT_STEP_TQ;
		end else begin
			// 13/256 is 5.08 %, inside the 5 % to 5.1 % band
			gbLo = gbPct;
			gbHi = gbPct;
		end
	end

	reg [`PWT_TIME_W-1:0] tgt_r;
	reg [`PWT_TIME_W-1:0] lo_r;
	reg [`PWT_TIME_W-1:0] hi_r;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tgt_r <= {`PWT_TIME_W{1'b0}};
			lo_r <= {`PWT_TIME_W{1'b0}};
			hi_r <= {`PWT_TIME_W{1'b0}};
		end else begin
			tgt_r <= tgt;
			lo_r <= (gbLo > tgt) ? {`PWT_TIME_W{1'b0}} : tgt - gbLo;
			hi_r <= tgt + gbHi;
		end
	end

	// ***************************************************
	// source select and edge detection
	// ***************************************************
	// the source chosen for the trigger feeds the counter too
	wire srcBit = (src < `PWT_NSRC) ? trigIn[src] : 1'b0;
	// active level follows pulse polarity
	wire lvl = ctrl_r[`PWT_F_POS] ? srcBit : ~srcBit;
	reg prevLvl_r;
	wire lead = lvl & ~prevLvl_r;
	wire trail = ~lvl & prevLvl_r;
	// a settings change or pending one in the pipeline aborts timing
	reg cfgDly_r;
	wire cfgChange = wrCtrl | wrWidthStb | cfgDly_r;

	// ***************************************************
	// width measurement
	// ***************************************************
	reg [`PWT_TIME_W-1:0] cnt_r;
	wire cntSat = (cnt_r > ~`PWT_CLK_TQ);
	wire [`PWT_TIME_W-1:0] cntInc = cntSat ? {`PWT_TIME_W{1'b1}} : cnt_r + `PWT_CLK_TQ;
	wire ending = timing_r & trail;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prevLvl_r <= 1'b0;
			cfgDly_r <= 1'b0;
			cnt_r <= {`PWT_TIME_W{1'b0}};
			timing_r <= 1'b0;
			lastW_r <= {`PWT_TIME_W{1'b0}};
		end else begin
			prevLvl_r <= lvl;
			cfgDly_r <= wrCtrl | wrWidthStb;
			if (cfgChange) begin
				timing_r <= 1'b0;
				cnt_r <= {`PWT_TIME_W{1'b0}};
			end else if (lead) begin
				timing_r <= 1'b1;
				cnt_r <= `PWT_CLK_TQ;
			end else if (ending) begin
				timing_r <= 1'b0;
				lastW_r <= cnt_r;
			end else if (timing_r) begin
				cnt_r <= cntInc;
			end
		end
	end

	// ***************************************************
	// trigger decision
	// ***************************************************
	reg hit;
	always @* begin
		hit = 1'b0;
		if (!cfgChange && timing_r) begin
			case (mode)
				`PWT_MODE_LT: hit = trail & (cnt_r < tgt_r);
				`PWT_MODE_GT: hit = lvl & ~fired_r & (cnt_r > tgt_r);
				`PWT_MODE_EQ: hit = trail & (cnt_r >= lo_r) & (cnt_r <= hi_r);
				`PWT_MODE_NE: begin
					if (trail)
						hit = (cnt_r < lo_r);
					else
						hit = ~fired_r & (cnt_r > hi_r);
				end
				default: hit = 1'b0;
			endcase
		end
	end

	wire pulseTrig = (trigType == `PWT_TYPE_PULSE) & hit;
	wire edgeTrig = (trigType == `PWT_TYPE_EDGE) & lead;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			trigOut <= 1'b0;
			fired_r <= 1'b0;
		end else begin
			trigOut <= pulseTrig | edgeTrig;
			if (cfgChange || lead)
				fired_r <= 1'b0;
			else if (pulseTrig)
				fired_r <= 1'b1;
		end
	end

	// ***************************************************
	// frequency counter
	// ***************************************************
	// qualified pulses or plain edges; video disables it
	wire countEvent = pulseTrig | edgeTrig;
	wire cntEnable = (trigType == `PWT_TYPE_PULSE) | (trigType == `PWT_TYPE_EDGE);

	// gate window resolves down to 10 Hz (2.5 events per window)
	freq_gate_counter #(
		.GATE_CYCLES(GATE_CYCLES)
	) uFreq (
		.clock(clock),
		.rst_n(rst_n),
		.enable(cntEnable),
		.countEvent(countEvent),
		.freqHz_r(freqHz),
		.freqValid_r(freqValid)
	);
endmodule // pulse_width_trigger_counter

// ---- verification/pwt_checker_assertions.sv ----
// port assertions for the pulse-width trigger qualifier
`timescale 1ns/1ps
`include "pwt_map.vh"
module pwt_checker #(
	parameter GATE_CYCLES = 40
) (
	input wire clock, // clock
	input wire rst_n, // reset
	input wire psel, // select
	input wire penable, // access
	input wire pwrite, // write
	input wire [`PWT_ADDR_W-1:0] paddr, // address
	input wire [31:0] pwdata, // wdata
	input wire [31:0] prdata, // rdata
	input wire pready, // ready
	input wire pslverr, // error
	input wire [`PWT_NSRC-1:0] trigIn, // levels
	input wire trigOut, // trigger
	input wire freqValid // valid
);
	reg [7:0] ctrl_r;
	reg [29:0] width_r;
	reg [8:0] quiet_r;
	reg [8:0] run_r;
	wire wrCfg = psel && penable && pwrite && paddr <= 8'h04;
	wire act = trigIn[ctrl_r[7:5]] == ctrl_r[2];
	wire trail = !act && run_r != 9'h000;
	wire ltSafe = ctrl_r[4:0] == 5'h0C && quiet_r > run_r + 9'h003;
	wire shortP = run_r * 100 < width_r * 33;
	wire unmap = paddr > 8'h10 || paddr[1:0] != 2'h0;
	// ******************
	// mirror of settings
	// ******************
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= 8'h04;
			width_r <= 30'h0000_0002;
			quiet_r <= 9'h000;
			run_r <= 9'h000;
		end else begin
			if (wrCfg && paddr == 8'h00) ctrl_r <= pwdata[7:0];
			if (wrCfg && paddr == 8'h04) width_r <= pwdata[29:0];
			quiet_r <= wrCfg ? 9'h000 : quiet_r + (quiet_r < 9'h0FF);
			run_r <= act ? run_r + (run_r < 9'h0FF) : 9'h000;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	AST_READY: assert property (psel |-> pready)
		else $error("ready low");
	AST_UNMAP: assert property (psel && penable && unmap |-> pslverr)
		else $error("no error");
	AST_MAPPED: assert property (psel && penable && !unmap |-> !pslverr)
		else $error("false error");
	AST_ONE: assert property (trigOut |=> !trigOut)
		else $error("long trigger");
	AST_LT_FIRE: assert property (trail && ltSafe && shortP |=> trigOut)
		else $error("missed trigger");
	AST_LT_QUIET: assert property (trail && ltSafe && !shortP |=> !trigOut)
		else $error("extra trigger");
	AST_EDGE: assert property (ctrl_r[4:3] == 2'h0 && quiet_r > 9'h003 && act && run_r == 9'h000
		|=> trigOut)
		else $error("edge missed");
	AST_VIDEO: assert property (ctrl_r[4:3] == 2'h2 && quiet_r > 9'h003 |-> !trigOut)
		else $error("video trigger");
endmodule // pwt_checker

// ---- verification/pulse_source.sv ----
// comparator-side pulse generator
`timescale 1ns/1ps
module pulse_source (
	input wire clock, // clock
	input wire start, // begin burst
	input wire [7:0] len, // active cycles
	input wire [7:0] gap, // idle cycles
	input wire [7:0] reps, // pulse count
	input wire [2:0] src, // lane
	input wire activeHigh, // polarity
	output reg [4:0] trigIn, // levels
	output reg busy // burst running
);
	integer n;
	initial begin
		trigIn = 5'h00;
		busy = 1'b0;
		forever begin
			@(posedge clock);
			if (start === 1'b1) begin
				busy <= 1'b1;
				// idle level first so polarity changes settle before pulses
				trigIn <= {5{!activeHigh}};
				repeat (gap) @(posedge clock);
				for (n = 0; n < reps; n = n + 1) begin
					trigIn[src] <= activeHigh;
					repeat (len) @(posedge clock);
					trigIn[src] <= !activeHigh;
					repeat (gap) @(posedge clock);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule // pulse_source

// ---- verification/tb_top.sv ----
// self-checking bench for the pulse-width trigger qualifier
`timescale 1ns/1ps
`include "pwt_map.vh"
module tb_top;
	reg clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, start = 0, pol = 1, err;
	reg [7:0] paddr = 0, len = 1, reps = 0;
	reg [2:0] src = 0;
	reg [31:0] pwdata = 0, q;
	wire [31:0] prdata;
	wire pready, pslverr, trigOut, freqValid, busy;
	wire [4:0] trigIn;
	integer bad_count = 0, tests_run = 0, fires = 0, k;
	initial forever #25 clock = ~clock;
	always @(posedge clock) if (trigOut === 1'b1) fires <= fires + 1;
	pulse_width_trigger_counter #(.GATE_CYCLES(40)) i_pulse_width_trigger_counter (
		.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trigIn(trigIn), .trigOut(trigOut), .freqValid(freqValid));
	pulse_source i_pulse_source (.clock(clock), .start(start), .len(len), .gap(8'h05),
		.reps(reps), .src(src), .activeHigh(pol), .trigIn(trigIn), .busy(busy));
	task close_out;
		$display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task cmp(input [31:0] g, input [31:0] e);
		tests_run = tests_run + 1;
		if (g !== e) begin
			bad_count = bad_count + 1;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task hang;
		bad_count = bad_count + 1;
		$display("[ERR] %0t wait timed out", $time);
		close_out;
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		@(posedge clock);
		for (k = 0; pready !== 1'b1; k = k + 1) begin
			if (k == 20) hang;
			@(posedge clock);
		end
		q = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clock);
	endtask
	task burst(input p, input [2:0] s, input [7:0] r, input [7:0] l, input wt);
		pol <= p;
		src <= s;
		reps <= r;
		len <= l;
		start <= 1;
		@(posedge clock);
		start <= 0;
		@(posedge clock);
		for (k = 0; wt && busy === 1'b1; k = k + 1) begin
			if (k == 3000) hang;
			@(posedge clock);
		end
	endtask
	task run_case(input [7:0] c, input [7:0] w, input [2:0] s, input [7:0] l, input [31:0] e);
		integer b;
		burst(c[2], s, 8'h00, l, 1'b1);
		apb(1'b1, 8'h00, c);
		apb(1'b1, 8'h04, w);
		b = fires;
		burst(c[2], s, 8'h01, l, 1'b1);
		repeat (3) @(posedge clock);
		cmp(fires - b, e);
	endtask
	task fcase(input [7:0] c, input [7:0] w, input [31:0] e);
		apb(1'b1, 8'h00, c);
		apb(1'b1, 8'h04, w);
		burst(1'b1, 3'h0, 8'h28, 8'h03, 1'b0);
		repeat (200) @(posedge clock);
		apb(1'b0, 8'h08, 32'h0000_0000);
		cmp(q, e);
		cmp(freqValid, 1'b1);
		burst(1'b1, 3'h0, 8'h00, 8'h03, 1'b1);
	endtask
	task t_regs;
		apb(1'b0, 8'h00, 32'h0000_0000);
		cmp(q, 32'h0000_0004);
		apb(1'b1, 8'h04, 32'h0000_0000);
		apb(1'b0, 8'h04, 32'h0000_0000);
		cmp(q, 32'h0000_0002);
		apb(1'b1, 8'h04, 32'hFFFF_FFFF);
		apb(1'b0, 8'h04, 32'h0000_0000);
		cmp(q, 32'h241F_C03E);
		apb(1'b0, 8'h14, 32'h0000_0000);
		cmp(err, 1'b1);
	endtask
	task t_modes;
		run_case(8'h0C, 8'h0A, 3'h0, 8'h03, 1'b1);
		run_case(8'h0C, 8'h0A, 3'h0, 8'h04, 1'b0);
		run_case(8'h08, 8'h0A, 3'h0, 8'h03, 1'b1);
		run_case(8'h0D, 8'h0A, 3'h0, 8'h05, 1'b1);
		run_case(8'h0D, 8'h0A, 3'h0, 8'h03, 1'b0);
		run_case(8'h0E, 8'h06, 3'h0, 8'h02, 1'b1);
		run_case(8'h0E, 8'h06, 3'h0, 8'h01, 1'b0);
		run_case(8'h0E, 8'h06, 3'h0, 8'h03, 1'b0);
		run_case(8'h0F, 8'h06, 3'h0, 8'h01, 1'b1);
		run_case(8'h0F, 8'h06, 3'h0, 8'h02, 1'b0);
		run_case(8'h0F, 8'h06, 3'h0, 8'h04, 1'b1);
		run_case(8'h0F, 8'h0E, 3'h0, 8'h05, 1'b0);
		run_case(8'h0E, 8'h0E, 3'h0, 8'h05, 1'b0);
		run_case(8'h0E, 8'h28, 3'h0, 8'h0D, 1'b1);
		run_case(8'h0E, 8'h28, 3'h0, 8'h0F, 1'b0);
		run_case(8'h04, 8'h0A, 3'h0, 8'h03, 1'b1);
		run_case(8'h6C, 8'h0A, 3'h3, 8'h03, 1'b1);
		run_case(8'h6C, 8'h0A, 3'h0, 8'h03, 1'b0);
		run_case(8'h14, 8'h0A, 3'h0, 8'h03, 1'b0);
	endtask
	task t_abort;
		integer b;
		apb(1'b0, 8'h0C, 32'h0000_0000);
		cmp(q, 32'h0000_0025);
		apb(1'b1, 8'h00, 32'h0000_000D);
		apb(1'b1, 8'h04, 32'h0000_0028);
		b = fires;
		burst(1'b1, 3'h0, 8'h01, 8'h14, 1'b0);
		repeat (8) @(posedge clock);
		apb(1'b1, 8'h04, 32'h0000_0028);
		burst(1'b1, 3'h0, 8'h00, 8'h03, 1'b1);
		cmp(fires - b, 32'h0000_0000);
	endtask
	task t_freq;
		fcase(8'h04, 8'h0A, 32'h0000_0014);
		fcase(8'h0C, 8'h0A, 32'h0000_0014);
		fcase(8'h0E, 8'h06, 32'h0000_0000);
		apb(1'b1, 8'h00, 32'h0000_0014);
		repeat (100) @(posedge clock);
		cmp(freqValid, 1'b0);
	endtask
	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1;
		@(posedge clock);
		t_regs;
		t_modes;
		t_abort;
		t_freq;
		close_out;
	end
endmodule // tb_top
bind pulse_width_trigger_counter pwt_checker #(.GATE_CYCLES(GATE_CYCLES)) i_pwt_checker (
	.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.trigIn(trigIn), .trigOut(trigOut), .freqValid(freqValid));
